// >>> hw/advc_dev.sv
// DAC mode control: static pins, serial command port, fade counter
`timescale 1ns/1ps
`default_nettype none
module advc_dev
  import advc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins
  advc_if.dev pins,
  // Decoded controls toward the datapath
  output logic [6:0] fade_level_q,
  output logic emphasis_on_q,
  output logic double_speed_q,
  output logic [1:0] format_q,
  output logic [4:0] word_bits_q,
  output logic [7:0] mode_control_q
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] s1_q, s2_q, s1_d; // Two stage sync of all pins
  logic [7:0] prev_q; // Previous synced values for edges
  logic [1:0] warm_q, warm_d; // Sync fill count after reset
  logic armed; // Edges valid once prev_q holds real pin levels
  always_comb begin
    // Saturates at three: s1, s2 and prev_q all hold pin levels then
    warm_d = (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
    s1_d = {pins.word_select, pins.format_select,
            pins.emphasis_or_guard_pin, pins.mute_or_strobe_pin,
            pins.speed_or_shiftclk_pin, pins.atten_or_serdata_pin,
            pins.control_style_select};
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      prev_q <= 8'h00;
      warm_q <= 2'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s1_q;
      prev_q <= s2_q;
      warm_q <= warm_d;
    end
  end
  logic style, sdat, sclk, strb, guard, ws;
  logic [1:0] fmt;
  assign style = s2_q[0];
  assign sdat = s2_q[1];
  assign sclk = s2_q[2];
  assign strb = s2_q[3];
  assign guard = s2_q[4];
  assign fmt = s2_q[6:5];
  assign ws = s2_q[7];
  logic serial_mode, sclk_rise, strb_rise, word_edge;
  assign serial_mode = style & ~guard;
  // Pins idle high while prev_q resets low: gate the false edge after reset
  assign armed = (warm_q == 2'h3);
  assign sclk_rise = armed & sclk & ~prev_q[2];
  assign strb_rise = armed & strb & ~prev_q[3];
  assign word_edge = armed & (ws ^ prev_q[7]); // Word boundary
  // ----------------------------------------
  // Serial command port
  // ----------------------------------------
  logic [7:0] shift_q, shift_d, mode_d;
  logic cmd_pulse_q, cmd_pulse_d; // One cycle: execute mode register
  always_comb begin
    shift_d = shift_q;
    mode_d = mode_control_q;
    cmd_pulse_d = 1'b0;
    if (serial_mode) begin
      if (!strb && sclk_rise) begin
        shift_d = {shift_q[6:0], sdat};
      end
      if (strb_rise && sclk) begin
        mode_d = shift_q;
        cmd_pulse_d = 1'b1;
      end // Strobe rise with clock low dropped
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 8'h00;
      mode_control_q <= ADVC_MODE_RST;
      cmd_pulse_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      mode_control_q <= mode_d;
      cmd_pulse_q <= cmd_pulse_d;
    end
  end
  // ----------------------------------------
  // Volume, emphasis and speed
  // ----------------------------------------
  // Saturating step of the fade counter
  function automatic logic [6:0] advc_step(input logic [6:0] v,
                                           input logic up);
    if (up) begin
      advc_step = (v >= ADVC_LVL_FULL) ? ADVC_LVL_FULL : v + 7'h01;
    end else begin
      advc_step = (v == ADVC_LVL_MUTE) ? ADVC_LVL_MUTE : v - 7'h01;
    end
  endfunction : advc_step
  logic [6:0] fade_d, target_q, target_d;
  logic ramp_q, ramp_d; // Mute ramp in progress
  logic emph_d, dsp_d, emph_req;
  logic [1:0] fmt_d;
  logic [4:0] bits_d;
  always_comb begin
    fade_d = fade_level_q;
    target_d = target_q;
    ramp_d = ramp_q;
    emph_d = emphasis_on_q;
    dsp_d = double_speed_q;
    fmt_d = format_q;
    bits_d = word_bits_q;
    if (serial_mode) begin
      emph_req = mode_control_q[ADVC_B_EMPH];
      dsp_d = ~mode_control_q[ADVC_B_DSPEED_N];
      if (cmd_pulse_q) begin
        if (mode_control_q[ADVC_B_FULL]) begin
          target_d = ADVC_LVL_FULL;
          ramp_d = 1'b0;
        end else if (!mode_control_q[ADVC_B_MUTE_N]) begin
          target_d = ADVC_LVL_MUTE;
          ramp_d = 1'b1;
        end else if (!mode_control_q[ADVC_B_ATTEN_N]) begin
          if (fade_level_q > ADVC_LVL_ATT) begin
            target_d = ADVC_LVL_ATT;
          end
        end else if (mode_control_q[ADVC_B_UP]) begin
          target_d = advc_step(fade_level_q, 1'b1);
          ramp_d = 1'b0; // Steps take over after a mute
        end else if (mode_control_q[ADVC_B_DOWN]) begin
          target_d = advc_step(fade_level_q, 1'b0);
          ramp_d = 1'b0; // Steps take over after a mute
        end
      end
    end else begin
      emph_req = guard;
      dsp_d = ~sclk;
      ramp_d = ~strb;
      if (strb) begin
        target_d = sdat ? ADVC_LVL_FULL : ADVC_LVL_ATT;
      end else begin
        target_d = ADVC_LVL_MUTE;
      end
    end
    if (word_edge) begin
      emph_d = emph_req;
      fmt_d = fmt;
      unique case (fmt)
        ADVC_FMT_I2S: bits_d = 5'h14; // Up to 20 bits
        ADVC_FMT_L16: bits_d = 5'h10;
        ADVC_FMT_L18: bits_d = 5'h12;
        ADVC_FMT_L20: bits_d = 5'h14;
      endcase
      if (ramp_d && fade_level_q != ADVC_LVL_MUTE) begin
        fade_d = advc_step(fade_level_q, 1'b0);
      end else if (!ramp_d) begin
        fade_d = target_d;
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fade_level_q <= ADVC_LVL_FULL;
      target_q <= ADVC_LVL_FULL;
      ramp_q <= 1'b0;
      emphasis_on_q <= 1'b0;
      double_speed_q <= 1'b0;
      format_q <= ADVC_FMT_I2S;
      word_bits_q <= 5'h14;
    end else begin
      fade_level_q <= fade_d;
      target_q <= target_d;
      ramp_q <= ramp_d;
      emphasis_on_q <= emph_d;
      double_speed_q <= dsp_d;
      format_q <= fmt_d;
      word_bits_q <= bits_d;
    end
  end
endmodule : advc_dev
`default_nettype wire

// >>> hw/advc_host.sv
// Host end: writes mode commands over the serial port, or drives static pins
`timescale 1ns/1ps
`default_nettype none
module advc_host
  import advc_pkg::*;
#(
  parameter int STEP_GAP_CYC = ADVC_STEP_GAP_CYC
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins
  advc_if.host pins,
  // Software port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q
);
  // ----------------------------------------
  // Registers: 0 command, 1 control, 2 status
  // ----------------------------------------
  localparam logic [1:0] A_CMD = 2'h0; // Write: send byte; bit0 unused
  localparam logic [1:0] A_CTRL = 2'h1; // b0 serial, b1 repeat, b5:2 static
  localparam logic [1:0] A_STAT = 2'h2; // b0 busy
  logic [7:0] cmd_q, cmd_d, ctrl_q, ctrl_d, rdata_d;
  advc_hstate_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [31:0] cnt_q, cnt_d;
  logic dat_q, dat_d, clk_q, clk_d, stb_q, stb_d;
  logic busy, is_step;
  assign busy = (st_q != ADVC_H_IDLE);
  assign is_step = cmd_q[ADVC_B_UP] | cmd_q[ADVC_B_DOWN];
  // ----------------------------------------
  // Sequencer and software port
  // ----------------------------------------
  always_comb begin
    cmd_d = cmd_q;
    ctrl_d = ctrl_q;
    st_d = st_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    dat_d = dat_q;
    clk_d = clk_q;
    stb_d = stb_q;
    rdata_d = 8'h00;
    if (rd) begin
      rdata_d = (addr == A_CTRL) ? ctrl_q :
                (addr == A_STAT) ? {7'h00, busy} :
                (addr == A_CMD) ? cmd_q : 8'h00;
    end
    if (wr && addr == A_CTRL) begin
      ctrl_d = wdata;
    end
    unique case (st_q)
      ADVC_H_IDLE: begin
        if (wr && addr == A_CMD && ctrl_q[0]) begin
          cmd_d = wdata;
          cnt_d = 32'h0;
          if (ctrl_q[1]) begin
            st_d = ADVC_H_LATCH; // Repeat: strobe only, clock stays high
            stb_d = 1'b0;
          end else begin
            st_d = ADVC_H_LOW; // full eight bits follow
            bit_d = ADVC_SHIFT_BITS;
            stb_d = 1'b0;
            clk_d = 1'b0;
            dat_d = wdata[7];
          end
        end
      end
      ADVC_H_LOW: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == ADVC_HALF_DIV - 1) begin
          cnt_d = 32'h0;
          clk_d = 1'b1; // Device shifts on this rise
          bit_d = bit_q - 4'h1;
          st_d = ADVC_H_HIGH;
        end
      end
      ADVC_H_HIGH: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == ADVC_HALF_DIV - 1) begin
          cnt_d = 32'h0;
          if (bit_q == 4'h0) begin
            st_d = ADVC_H_LATCH; // Clock left high for the strobe
          end else begin
            clk_d = 1'b0;
            dat_d = cmd_q[bit_q[2:0] - 3'h1];
            st_d = ADVC_H_LOW;
          end
        end
      end
      ADVC_H_LATCH: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == ADVC_HALF_DIV - 1) begin
          cnt_d = 32'h0;
          stb_d = 1'b1; // Strobe rise with clock high
          st_d = ADVC_H_WAIT;
        end
      end
      ADVC_H_WAIT: begin
        cnt_d = cnt_q + 32'h1;
        if (!is_step || cnt_q >= STEP_GAP_CYC - 1) begin
          cnt_d = 32'h0;
          st_d = ADVC_H_IDLE;
        end
      end
      default: st_d = ADVC_H_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= ADVC_MODE_RST;
      ctrl_q <= 8'h3C;
      st_q <= ADVC_H_IDLE;
      bit_q <= 4'h0;
      cnt_q <= 32'h0;
      dat_q <= 1'b0;
      clk_q <= 1'b1;
      stb_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      cmd_q <= cmd_d;
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      clk_q <= clk_d;
      stb_q <= stb_d;
      rdata_q <= rdata_d;
    end
  end
  // ----------------------------------------
  // Pin drive: serial port or static levels
  // ----------------------------------------
  logic [4:0] pin_d; // Next pin levels, from next register values
  // Pick pin levels one step ahead so that the pins come from flops
  always_comb begin
    pin_d[0] = ctrl_d[0];
    pin_d[1] = ctrl_d[0] ? dat_d : ctrl_d[2];
    pin_d[2] = ctrl_d[0] ? clk_d : ctrl_d[3];
    pin_d[3] = ctrl_d[0] ? stb_d : ctrl_d[4];
    pin_d[4] = ctrl_d[0] ? 1'b0 : ctrl_d[5];
  end
  // Register the pins: no mux glitch reaches the far clock domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // Static mode with all pins high, as the control reset gives
      pins.control_style_select <= 1'b0;
      pins.atten_or_serdata_pin <= 1'b1;
      pins.speed_or_shiftclk_pin <= 1'b1;
      pins.mute_or_strobe_pin <= 1'b1;
      pins.emphasis_or_guard_pin <= 1'b1;
    end else begin
      pins.control_style_select <= pin_d[0];
      pins.atten_or_serdata_pin <= pin_d[1];
      pins.speed_or_shiftclk_pin <= pin_d[2];
      pins.mute_or_strobe_pin <= pin_d[3];
      pins.emphasis_or_guard_pin <= pin_d[4];
    end
  end
endmodule : advc_host
`default_nettype wire

// >>> include/advc_if.sv
// Pin-level link between the control host and the DAC control block
`timescale 1ns/1ps
`default_nettype none
interface advc_if;
  logic control_style_select; // High: serial port, low: static pins
  logic atten_or_serdata_pin; // Attenuate pin or serial data
  logic speed_or_shiftclk_pin; // Speed pin or shift clock
  logic mute_or_strobe_pin; // Mute pin or latch strobe
  logic emphasis_or_guard_pin; // De-emphasis pin or guard (low)
  logic [1:0] format_select; // {format_select_hi, format_select_lo}
  logic word_select; // Word clock from audio source
  modport dev (
    input control_style_select, atten_or_serdata_pin, speed_or_shiftclk_pin,
    input mute_or_strobe_pin, emphasis_or_guard_pin, format_select,
    input word_select
  );
  modport host (
    output control_style_select, atten_or_serdata_pin, speed_or_shiftclk_pin,
    output mute_or_strobe_pin, emphasis_or_guard_pin
  );
endinterface : advc_if
`default_nettype wire

// >>> include/advc_pkg.sv
// Shared constants and types for the audio DAC mode and volume control
package advc_pkg;
  // ----------------------------------------
  // Format select codes
  // ----------------------------------------
  localparam logic [1:0] ADVC_FMT_I2S = 2'h0; // Standard format, 256x clock
  localparam logic [1:0] ADVC_FMT_L16 = 2'h1; // LSB justified 16 bit
  localparam logic [1:0] ADVC_FMT_L18 = 2'h2; // LSB justified 18 bit
  localparam logic [1:0] ADVC_FMT_L20 = 2'h3; // LSB justified 20 bit
  // ----------------------------------------
  // Mode register bit positions
  // ----------------------------------------
  localparam int ADVC_B_ATTEN_N = 7; // Attenuate, active low
  localparam int ADVC_B_DSPEED_N = 6; // Double speed, active low
  localparam int ADVC_B_MUTE_N = 5; // Mute, active low
  localparam int ADVC_B_EMPH = 4; // De-emphasis, active high
  localparam int ADVC_B_FULL = 3; // Full scale, active high
  localparam int ADVC_B_UP = 2; // Step up, active high
  localparam int ADVC_B_DOWN = 1; // Step down, active high
  localparam logic [7:0] ADVC_MODE_RST = 8'hE8; // Quiet defaults: full scale
  // ----------------------------------------
  // Fade counter levels
  // ----------------------------------------
  localparam logic [6:0] ADVC_LVL_FULL = 7'h78; // 120
  localparam logic [6:0] ADVC_LVL_ATT = 7'h1E; // 30
  localparam logic [6:0] ADVC_LVL_MUTE = 7'h00; // 0
  localparam logic [3:0] ADVC_SHIFT_BITS = 4'h8; // Bits in one command
  // ----------------------------------------
  // Host timing
  // ----------------------------------------
  localparam int ADVC_CLK_MHZ = 100; // System clock rate
  localparam int ADVC_STEP_GAP_MS = 22; // Least gap between steps
  localparam int ADVC_STEP_GAP_CYC = ADVC_STEP_GAP_MS * 1000 * ADVC_CLK_MHZ;
  localparam int ADVC_HALF_DIV = 4; // Host shift clock half period
  // Host sequencer states
  typedef enum logic [4:0] {
    ADVC_H_IDLE = 5'h01,
    ADVC_H_LOW = 5'h02,
    ADVC_H_HIGH = 5'h04,
    ADVC_H_LATCH = 5'h08,
    ADVC_H_WAIT = 5'h10
  } advc_hstate_t;
endpackage : advc_pkg

// >>> test/advc_chk.sv
// Checker for the host-to-DAC control link pins and fade level
`timescale 1ns/1ps
`default_nettype none
module advc_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Link pins
  input wire logic control_style_select,
  input wire logic atten_or_serdata_pin,
  input wire logic speed_or_shiftclk_pin,
  input wire logic mute_or_strobe_pin,
  input wire logic emphasis_or_guard_pin,
  input wire logic word_select,
  // Device fade level
  input wire logic [6:0] fade_level_q
);
  wire ser = control_style_select; // Serial port active
  wire ck = speed_or_shiftclk_pin; // Shift clock
  wire st = mute_or_strobe_pin; // Latch strobe
  logic [3:0] bits_q; // Shift clock rises while strobe low
  logic [3:0] age_q; // Cycles since a word edge
  logic ws_q; // Word select one cycle ago
  // Count shifted bits and word edge age
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bits_q <= 4'h0;
      age_q <= 4'hF;
      ws_q <= 1'b0;
    end else begin
      ws_q <= word_select;
      if (word_select != ws_q) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
      if (st) bits_q <= 4'h0;
      else if ($rose(ck) && bits_q != 4'hF) bits_q <= bits_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_latch_clk_high: assert property (ser && $rose(st) |-> ck)
    else $error("strobe rose with shift clock low");
  a_eight_bits: assert property (ser && $rose(st) |->
    bits_q == 4'h0 || bits_q >= 4'h8) else $error("short command");
  a_repeat_clk: assert property (ser && st |-> ck)
    else $error("shift clock low between strobes");
  a_guard_low: assert property (ser |-> !emphasis_or_guard_pin)
    else $error("guard pin high in serial mode");
  a_data_hold: assert property (ser && !st && $rose(ck) |->
    $stable(atten_or_serdata_pin)) else $error("data moved at shift");
  a_clk_high_len: assert property (ser && !st && $rose(ck) |->
    ck[*4]) else $error("shift clock high too short");
  a_clk_low_len: assert property (ser && $fell(ck) |->
    (!ck)[*4] ##1 ck) else $error("shift clock low time wrong");
  a_fade_max: assert property (fade_level_q <= 7'h78)
    else $error("fade level above full");
  a_fade_at_word: assert property ($changed(fade_level_q) |->
    age_q <= 4'h6) else $error("fade moved away from word edge");
endmodule : advc_chk
`default_nettype wire

// >>> test/audio_dac_mode_and_volume_control_bench.sv
// Self-checking bench for the DAC control host and device ends
`timescale 1ns/1ps
`default_nettype none
module audio_dac_mode_and_volume_control_bench;
  import advc_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clock, rstn, wr, rd, ck_q, ck2_q, emph, dbl;
  logic [1:0] addr, fmt;
  logic [4:0] wbits;
  logic [6:0] fade, fade2;
  logic [7:0] wdata, rdata_q, mode, mode2, last_q, lfsr, lc;
  logic [7:0] rq[$], mq[$]; // Expected reads and mode loads
  logic [17:0] sp[4] = '{18'h071E0, 18'h0E07A, 18'h0A002, 18'h0D1E3};
  logic [15:0] sv[13] = '{16'hF878, 16'h601E, 16'h611E, 16'hE41F,
    16'h0320, 16'h0321, 16'hE220, 16'hC000, 16'hE200, 16'hE401,
    16'hE878, 16'hE478, 16'hA878};
  int bad_count, cmp_count;
  advc_if bus();
  advc_if bus2();
  advc_host #(.STEP_GAP_CYC(20)) advc_host_i (.clock(clock), .rstn(rstn),
    .pins(bus), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q));
  advc_dev advc_dev_i (.clock(clock), .rstn(rstn), .pins(bus),
    .fade_level_q(fade), .emphasis_on_q(emph), .double_speed_q(dbl),
    .format_q(fmt), .word_bits_q(wbits), .mode_control_q(mode));
  // Second device fed by a rule-breaking driver
  advc_dev advc_dev_i2 (.clock(clock), .rstn(rstn), .pins(bus2),
    .fade_level_q(fade2), .emphasis_on_q(), .double_speed_q(),
    .format_q(), .word_bits_q(), .mode_control_q(mode2));
  advc_chk advc_chk_i (.clock(clock), .rstn(rstn),
    .control_style_select(bus.control_style_select),
    .atten_or_serdata_pin(bus.atten_or_serdata_pin),
    .speed_or_shiftclk_pin(bus.speed_or_shiftclk_pin),
    .mute_or_strobe_pin(bus.mute_or_strobe_pin),
    .emphasis_or_guard_pin(bus.emphasis_or_guard_pin),
    .word_select(bus.word_select), .fade_level_q(fade));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_t(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wr_t
  task automatic rd_t(input logic [1:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    ck_q <= 1'b1;
    rq.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
    ck_q <= 1'b0;
    @(posedge clock);
  endtask : rd_t
  // Poll busy, then let levels settle over many words
  task automatic idle();
    for (int i = 0; i < 300; i++) begin
      addr <= 2'h2;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      if (rdata_q[0] === 1'b0) break;
      @(posedge clock);
    end
    repeat (3000) @(posedge clock);
  endtask : idle
  task automatic p2(input logic c, input logic d, input logic s);
    bus2.speed_or_shiftclk_pin <= c;
    bus2.atten_or_serdata_pin <= d;
    bus2.mute_or_strobe_pin <= s;
    repeat (4) @(posedge clock);
  endtask : p2
  task automatic bits2(input logic [11:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      p2(1'b0, v[i], 1'b0);
      p2(1'b1, v[i], 1'b0);
    end
  endtask : bits2
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Processes
  // ----------------------------------------
  // Clock and word select
  initial begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  initial begin
    bus.word_select = 1'b0;
    bus2.word_select = 1'b0;
    forever begin
      repeat (20) @(posedge clock);
      bus.word_select <= !bus.word_select;
      bus2.word_select <= !bus.word_select;
    end
  end
  // Result watcher: read data and mode loads
  // Delay the read marker to the cycle in which read data stand
  always @(posedge clock) begin
    ck2_q <= ck_q;
  end
  // Sample at the falling edge, clear of the launching edge
  always @(negedge clock) begin
    if (ck2_q) chk("read data", rdata_q, rq.pop_front());
    if (rstn && mode !== last_q) chk("mode", mode, mq.pop_front());
    last_q <= mode;
  end
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {rstn, wr, rd, ck_q, addr, wdata, lc} = '0;
    {bus.format_select, bus2.format_select} = '0;
    bus2.emphasis_or_guard_pin = 1'b0;
    bus2.control_style_select = 1'b1;
    bus2.speed_or_shiftclk_pin = 1'b1;
    bus2.mute_or_strobe_pin = 1'b1;
    bus2.atten_or_serdata_pin = 1'b0;
    lfsr = 8'h5F;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int f = 3; f >= 0; f--) begin
      bus.format_select <= 2'(f);
      repeat (30) @(posedge clock); // Past the next word edge
      chk("format", {6'h00, fmt}, 8'(f));
      chk("bits", {3'h0, wbits}, f == 1 ? 8'h10 : f == 2 ? 8'h12 : 8'h14);
    end
    foreach (sp[i]) begin
      wr_t(2'h1, sp[i][17:10]);
      repeat (3000) @(posedge clock);
      chk("fade", {1'b0, fade}, sp[i][9:2]);
      chk("emphasis", {7'h00, emph}, {7'h00, sp[i][1]});
      chk("double", {7'h00, dbl}, {7'h00, sp[i][0]});
    end
    wr_t(2'h1, 8'h01);
    wr_t(2'h3, 8'hFF);
    rd_t(2'h1, 8'h01);
    foreach (sv[i]) begin
      if (sv[i][15:8] == 8'h03) begin
        wr_t(2'h1, 8'h03); // Repeat mode: strobe only
        wr_t(2'h0, lc);
      end else begin
        lc = sv[i][15:8];
        wr_t(2'h1, 8'h01);
        wr_t(2'h0, lc);
        mq.push_back(lc);
      end
      idle();
      chk("fade", {1'b0, fade}, sv[i][7:0]);
      chk("emphasis", {7'h00, emph}, {7'h00, lc[4]});
      chk("double", {7'h00, dbl}, {7'h00, !lc[6]});
    end
    lfsr = nx(nx(lfsr));
    bits2({lfsr[3:0], 8'hF8}, 12);
    p2(1'b1, 1'b1, 1'b1);
    chk("mode2", mode2, 8'hF8);
    bits2(12'h060, 8);
    p2(1'b0, 1'b0, 1'b0);
    p2(1'b0, 1'b1, 1'b1);
    repeat (3000) @(posedge clock);
    chk("mode2", mode2, 8'hF8);
    chk("fade2", {1'b0, fade2}, 8'h78);
    end_of_test();
  end
endmodule : audio_dac_mode_and_volume_control_bench
`default_nettype wire
